// ==== hdl/tivp_cfg.svh ====
/*
  Constants: setting limits, reset values, analog output scaling.
  Assumes 0.01 % or 1 mV per lsb.
*/
`ifndef TIVP_CFG_SVH
`define TIVP_CFG_SVH

// --------
// setting limits and reset values
// --------
`define TIVP_CFG_LIMIT 16'sh7530
`define TIVP_THRESH_RST 16'sh1770
`define TIVP_HI_VAL_RST 16'sh0001
`define TIVP_LO_VAL_RST 16'sh0000
`define TIVP_DIVIDER_RST 16'sh2710
`define TIVP_OFFSET_RST 16'sh0000
`define TIVP_ZERO_VAL 16'sh0000

// --------
// analog source slots
// --------
`define TIVP_SRC_SPEED_FB 3'h0
`define TIVP_SRC_SPEED_REF 3'h1
`define TIVP_SRC_CUR_DEMAND 3'h2
`define TIVP_SRC_FIELD_LSB 0

// --------
// analog output scaling
// --------
`define TIVP_DIV_UNITY 32'sh0000_2710
`define TIVP_DIV_ZERO_SAT 32'sh0001_0000
`define TIVP_AOUT_SPAN_MV 32'sh0000_2C24
`define TIVP_STEP_UV 32'sh0000_09C4
`define TIVP_UV_PER_MV 32'sh0000_03E8
`define TIVP_CODE_MAX 32'sh0000_0FFF

`endif

// ==== hdl/tivp_pkg.sv ====
/*
  Types shared by the terminal value processing block.
  Assumes the constants header is included by the design files.
*/
package tivp_pkg;

  // signed value: 0.01 % per lsb, or 1 mV per lsb for voltages
  typedef logic signed [15:0] tivp_val_t;

  // signed analog output code, 2.5 mV per lsb
  typedef logic signed [12:0] tivp_code_t;

  typedef logic [2:0] tivp_src_idx_t;

  typedef enum logic [2:0] {
    TIVP_UIN_THRESHOLD,
    TIVP_UIN_HIGH_OUT1,
    TIVP_UIN_LOW_OUT1,
    TIVP_UIN_HIGH_OUT2,
    TIVP_UIN_LOW_OUT2
  } tivp_uin_field_t;

  typedef enum logic [1:0] {
    TIVP_AOUT_SOURCE,
    TIVP_AOUT_DIVIDER,
    TIVP_AOUT_OFFSET,
    TIVP_AOUT_RECTIFY
  } tivp_aout_field_t;

  typedef enum logic {
    TIVP_DIN_HIGH,
    TIVP_DIN_LOW
  } tivp_din_field_t;

endpackage

// ==== hdl/tivp_aout_chan.sv ====
/*
  One analog output channel: divide, offset, limit, rectify, quantise.
  Assumes settings already limited to their ranges by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tivp_cfg.svh"

module tivp_aout_chan (
  input wire logic clk,
  input wire logic reset_n,
  input wire tivp_pkg::tivp_val_t src_value,
  input wire tivp_pkg::tivp_val_t divide_factor,
  input wire tivp_pkg::tivp_val_t offset,
  input wire logic rectify,
  output logic signed [12:0] out_code
);

  function automatic logic signed [31:0] clamp32(
    input logic signed [31:0] v,
    input logic signed [31:0] lim
  );
    if (v > lim) begin
      return lim;
    end else if (v < -lim) begin
      return -lim;
    end
    return v;
  endfunction

  logic signed [31:0] scaled;
  logic signed [31:0] summed;
  logic signed [31:0] volts_mv;
  logic signed [31:0] code_wide;
  tivp_pkg::tivp_code_t out_code_reg;
  tivp_pkg::tivp_code_t out_code_next;

  // --------
  // value chain
  // --------
  always_comb begin
    // a zero divider would be an infinite gain: saturate by sign instead
    if (divide_factor == `TIVP_ZERO_VAL) begin
      scaled = (src_value < `TIVP_ZERO_VAL) ? -`TIVP_DIV_ZERO_SAT :
               `TIVP_DIV_ZERO_SAT;
    end else begin
      scaled = (32'(src_value) * `TIVP_DIV_UNITY) / 32'(divide_factor);
    end
    summed = scaled + 32'(offset);
    volts_mv = clamp32(summed, `TIVP_AOUT_SPAN_MV);
    if (rectify && volts_mv < 0) begin
      volts_mv = -volts_mv;
    end
    code_wide = (volts_mv * `TIVP_UV_PER_MV) / `TIVP_STEP_UV;
    // the code range ends below the span limit: 12 bits stop at 10.2375 V
    out_code_next = 13'(clamp32(code_wide, `TIVP_CODE_MAX));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_code_reg <= '0;
    end else begin
      out_code_reg <= out_code_next;
    end
  end

  assign out_code = out_code_reg;

endmodule
`default_nettype wire

// ==== hdl/tivp_top.sv ====
/*
  Terminal value processing: universal, digital and run input value
  selection, and four analog outputs, the last fixed to armature current.
  Assumes converted samples synchronous to clk; each edge is one update.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tivp_cfg.svh"

// What this block does
// - high universal input selects output-1 high value
// - low universal input selects output-1 low value
// - output 2 has its own high value
// - output 2 has its own low value
// - per-input signed threshold, 6 V reset value
// - high only when strictly above the threshold
// - threshold comparison is signed
// - zero reads low, any nonzero reads high
// - four analog outputs, fourth is armature current
// - outputs quantised to 12 bits plus sign
// - outputs limited to 11.3 volts span
// - armature output bipolar or rectified, bipolar default
// - divide, then offset, then optional rectify
// - signed divider within 3.0000, reset 1.0000
// - 100 percent gives 10 V at unity
// - offset unaffected by the divider
// - scope select drives output 3 from display
// - reset sources: speed feedback, reference, current demand
// - digital inputs reset to 0.01 and 0.00
// - input offset never reaches the threshold comparator
// - each universal input feeds two independent outputs
module tivp_top #(
  parameter int NUM_UIN = 8,
  parameter int NUM_DIN = 4,
  parameter int NUM_SRC = 8,
  parameter int NUM_PAOUT = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire tivp_pkg::tivp_val_t cfg_data,
  input wire tivp_pkg::tivp_val_t uin_raw_mv [NUM_UIN],
  input wire logic [NUM_UIN-1:0] uin_cfg_we,
  input wire tivp_pkg::tivp_uin_field_t uin_cfg_field,
  output tivp_pkg::tivp_val_t uin_out1 [NUM_UIN],
  output tivp_pkg::tivp_val_t uin_out2 [NUM_UIN],
  output logic [NUM_UIN-1:0] uin_out1_logic,
  output logic [NUM_UIN-1:0] uin_out2_logic,
  output logic [NUM_UIN-1:0] universal_input_n,
  input wire logic [NUM_DIN-1:0] digital_input_n,
  input wire logic [NUM_DIN-1:0] din_cfg_we,
  input wire tivp_pkg::tivp_din_field_t din_cfg_field,
  output tivp_pkg::tivp_val_t din_value [NUM_DIN],
  output logic [NUM_DIN-1:0] din_logic,
  input wire logic run_terminal,
  input wire logic run_cfg_we,
  input wire tivp_pkg::tivp_din_field_t run_cfg_field,
  output tivp_pkg::tivp_val_t run_value,
  output logic run_logic,
  input wire tivp_pkg::tivp_val_t aout_src_values [NUM_SRC],
  input wire logic [NUM_PAOUT-1:0] aout_cfg_we,
  input wire tivp_pkg::tivp_aout_field_t aout_cfg_field,
  input wire tivp_pkg::tivp_val_t display_value,
  input wire logic scope_follow_display,
  input wire tivp_pkg::tivp_val_t armature_current,
  input wire logic arm_rectify_we,
  output logic armature_current_out_rectify,
  output logic signed [12:0] analog_output_n [NUM_PAOUT+1]
);

  // --------
  // helpers
  // --------
  function automatic tivp_pkg::tivp_val_t clamp_setting(
    input tivp_pkg::tivp_val_t v
  );
    if (v > `TIVP_CFG_LIMIT) begin
      return `TIVP_CFG_LIMIT;
    end else if (v < -`TIVP_CFG_LIMIT) begin
      return -`TIVP_CFG_LIMIT;
    end
    return v;
  endfunction

  function automatic logic as_logic(input tivp_pkg::tivp_val_t v);
    return v != `TIVP_ZERO_VAL;
  endfunction

  function automatic tivp_pkg::tivp_val_t pick(
    input logic high,
    input tivp_pkg::tivp_val_t hi_val,
    input tivp_pkg::tivp_val_t lo_val
  );
    return high ? hi_val : lo_val;
  endfunction

  // value writes beyond the documented range are held at the range ends; source and rectify writes take raw cfg_data bits
  tivp_pkg::tivp_val_t cfg_clamped;
  assign cfg_clamped = clamp_setting(cfg_data);

  // --------
  // universal input settings
  // --------
  tivp_pkg::tivp_val_t thresh_reg [NUM_UIN];
  tivp_pkg::tivp_val_t hi1_reg [NUM_UIN];
  tivp_pkg::tivp_val_t lo1_reg [NUM_UIN];
  tivp_pkg::tivp_val_t hi2_reg [NUM_UIN];
  tivp_pkg::tivp_val_t lo2_reg [NUM_UIN];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_UIN; i++) begin
        thresh_reg[i] <= `TIVP_THRESH_RST;
        hi1_reg[i] <= `TIVP_HI_VAL_RST;
        lo1_reg[i] <= `TIVP_LO_VAL_RST;
        hi2_reg[i] <= `TIVP_HI_VAL_RST;
        lo2_reg[i] <= `TIVP_LO_VAL_RST;
      end
    end else begin
      for (int i = 0; i < NUM_UIN; i++) begin
        if (uin_cfg_we[i]) begin
          case (uin_cfg_field)
            tivp_pkg::TIVP_UIN_THRESHOLD: begin
              thresh_reg[i] <= cfg_clamped;
            end
            tivp_pkg::TIVP_UIN_HIGH_OUT1: begin
              hi1_reg[i] <= cfg_clamped;
            end
            tivp_pkg::TIVP_UIN_LOW_OUT1: begin
              lo1_reg[i] <= cfg_clamped;
            end
            tivp_pkg::TIVP_UIN_HIGH_OUT2: begin
              hi2_reg[i] <= cfg_clamped;
            end
            tivp_pkg::TIVP_UIN_LOW_OUT2: begin
              lo2_reg[i] <= cfg_clamped;
            end
            default: begin
              thresh_reg[i] <= thresh_reg[i];
            end
          endcase
        end
      end
    end
  end

  // --------
  // universal input judgement and value selection
  // --------
  // the raw sample is compared, never the offset or scaled linear value
  logic [NUM_UIN-1:0] uin_high;
  always_comb begin
    for (int i = 0; i < NUM_UIN; i++) begin
      uin_high[i] = uin_raw_mv[i] > thresh_reg[i];
    end
  end

  tivp_pkg::tivp_val_t uin_out1_reg [NUM_UIN];
  tivp_pkg::tivp_val_t uin_out2_reg [NUM_UIN];
  logic [NUM_UIN-1:0] uin_out1_logic_reg;
  logic [NUM_UIN-1:0] uin_out2_logic_reg;
  logic [NUM_UIN-1:0] uin_high_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_UIN; i++) begin
        uin_out1_reg[i] <= `TIVP_LO_VAL_RST;
        uin_out2_reg[i] <= `TIVP_LO_VAL_RST;
      end
      uin_out1_logic_reg <= '0;
      uin_out2_logic_reg <= '0;
      uin_high_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_UIN; i++) begin
        uin_out1_reg[i] <= pick(uin_high[i], hi1_reg[i], lo1_reg[i]);
        uin_out2_reg[i] <= pick(uin_high[i], hi2_reg[i], lo2_reg[i]);
        uin_out1_logic_reg[i] <=
          as_logic(pick(uin_high[i], hi1_reg[i], lo1_reg[i]));
        uin_out2_logic_reg[i] <=
          as_logic(pick(uin_high[i], hi2_reg[i], lo2_reg[i]));
      end
      uin_high_reg <= uin_high;
    end
  end

  assign uin_out1 = uin_out1_reg;
  assign uin_out2 = uin_out2_reg;
  assign uin_out1_logic = uin_out1_logic_reg;
  assign uin_out2_logic = uin_out2_logic_reg;
  assign universal_input_n = uin_high_reg;

  // --------
  // digital inputs and run input used as a spare input
  // --------
  tivp_pkg::tivp_val_t din_hi_reg [NUM_DIN];
  tivp_pkg::tivp_val_t din_lo_reg [NUM_DIN];
  tivp_pkg::tivp_val_t run_hi_reg;
  tivp_pkg::tivp_val_t run_lo_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_DIN; i++) begin
        din_hi_reg[i] <= `TIVP_HI_VAL_RST;
        din_lo_reg[i] <= `TIVP_LO_VAL_RST;
      end
    end else begin
      for (int i = 0; i < NUM_DIN; i++) begin
        if (din_cfg_we[i]) begin
          case (din_cfg_field)
            tivp_pkg::TIVP_DIN_HIGH: begin
              din_hi_reg[i] <= cfg_clamped;
            end
            tivp_pkg::TIVP_DIN_LOW: begin
              din_lo_reg[i] <= cfg_clamped;
            end
            default: begin
              din_hi_reg[i] <= din_hi_reg[i];
            end
          endcase
        end
      end
    end
  end

  // reused run terminal: the configurer must hold the run destination high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_hi_reg <= `TIVP_HI_VAL_RST;
      run_lo_reg <= `TIVP_LO_VAL_RST;
    end else if (run_cfg_we) begin
      case (run_cfg_field)
        tivp_pkg::TIVP_DIN_HIGH: begin
          run_hi_reg <= cfg_clamped;
        end
        tivp_pkg::TIVP_DIN_LOW: begin
          run_lo_reg <= cfg_clamped;
        end
        default: begin
          run_hi_reg <= run_hi_reg;
        end
      endcase
    end
  end

  tivp_pkg::tivp_val_t din_value_reg [NUM_DIN];
  logic [NUM_DIN-1:0] din_logic_reg;
  tivp_pkg::tivp_val_t run_value_reg;
  logic run_logic_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_DIN; i++) begin
        din_value_reg[i] <= `TIVP_LO_VAL_RST;
      end
      din_logic_reg <= '0;
      run_value_reg <= `TIVP_LO_VAL_RST;
      run_logic_reg <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_DIN; i++) begin
        din_value_reg[i] <=
          pick(digital_input_n[i], din_hi_reg[i], din_lo_reg[i]);
        din_logic_reg[i] <=
          as_logic(pick(digital_input_n[i], din_hi_reg[i], din_lo_reg[i]));
      end
      run_value_reg <= pick(run_terminal, run_hi_reg, run_lo_reg);
      run_logic_reg <= as_logic(pick(run_terminal, run_hi_reg, run_lo_reg));
    end
  end

  assign din_value = din_value_reg;
  assign din_logic = din_logic_reg;
  assign run_value = run_value_reg;
  assign run_logic = run_logic_reg;

  // --------
  // analog output settings
  // --------
  tivp_pkg::tivp_src_idx_t aout_src_reg [NUM_PAOUT];
  tivp_pkg::tivp_val_t aout_div_reg [NUM_PAOUT];
  tivp_pkg::tivp_val_t aout_ofs_reg [NUM_PAOUT];
  logic [NUM_PAOUT-1:0] aout_rect_reg;
  logic arm_rect_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PAOUT; i++) begin
        aout_div_reg[i] <= `TIVP_DIVIDER_RST;
        aout_ofs_reg[i] <= `TIVP_OFFSET_RST;
      end
      aout_src_reg[0] <= `TIVP_SRC_SPEED_FB;
      aout_src_reg[1] <= `TIVP_SRC_SPEED_REF;
      aout_src_reg[2] <= `TIVP_SRC_CUR_DEMAND;
      aout_rect_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_PAOUT; i++) begin
        if (aout_cfg_we[i]) begin
          case (aout_cfg_field)
            tivp_pkg::TIVP_AOUT_SOURCE: begin
              aout_src_reg[i] <= cfg_data[`TIVP_SRC_FIELD_LSB +: 3];
            end
            tivp_pkg::TIVP_AOUT_DIVIDER: begin
              aout_div_reg[i] <= cfg_clamped;
            end
            tivp_pkg::TIVP_AOUT_OFFSET: begin
              aout_ofs_reg[i] <= cfg_clamped;
            end
            tivp_pkg::TIVP_AOUT_RECTIFY: begin
              aout_rect_reg[i] <= cfg_data[0];
            end
            default: begin
              aout_rect_reg[i] <= aout_rect_reg[i];
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arm_rect_reg <= 1'b0;
    end else if (arm_rectify_we) begin
      arm_rect_reg <= cfg_data[0];
    end
  end

  assign armature_current_out_rectify = arm_rect_reg;

  // --------
  // analog output channels
  // --------
  // scope select only overrides the fetch; the stored link stays intact
  tivp_pkg::tivp_val_t aout_fetch [NUM_PAOUT];
  always_comb begin
    for (int i = 0; i < NUM_PAOUT; i++) begin
      aout_fetch[i] = (int'(aout_src_reg[i]) < NUM_SRC) ?
                      aout_src_values[aout_src_reg[i]] : `TIVP_ZERO_VAL;
    end
    if (scope_follow_display) begin
      aout_fetch[NUM_PAOUT-1] = display_value;
    end
  end

  for (genvar g = 0; g < NUM_PAOUT; g++) begin : g_paout
    tivp_aout_chan u_chan (
      .clk(clk),
      .reset_n(reset_n),
      .src_value(aout_fetch[g]),
      .divide_factor(aout_div_reg[g]),
      .offset(aout_ofs_reg[g]),
      .rectify(aout_rect_reg[g]),
      .out_code(analog_output_n[g])
    );
  end

  // committed armature output: unity divider, no offset
  tivp_aout_chan u_arm_chan (
    .clk(clk),
    .reset_n(reset_n),
    .src_value(armature_current),
    .divide_factor(`TIVP_DIVIDER_RST),
    .offset(`TIVP_OFFSET_RST),
    .rectify(arm_rect_reg),
    .out_code(analog_output_n[NUM_PAOUT])
  );

endmodule
`default_nettype wire

// ==== testbench/tivp_monitor.sv ====
/*
  Checker for tivp_top: value readings, held selections and analog codes.
  Assumes one clock, clk, and the asynchronous active-low reset_n.
*/
`timescale 1ns/100ps
`default_nettype none
module tivp_monitor #(
  parameter int NUM_UIN = 8,
  parameter int NUM_DIN = 4,
  parameter int NUM_PAOUT = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [NUM_UIN-1:0] uin_cfg_we,
  input wire tivp_pkg::tivp_val_t uin_out1 [NUM_UIN],
  input wire tivp_pkg::tivp_val_t uin_out2 [NUM_UIN],
  input wire logic [NUM_UIN-1:0] uin_out1_logic,
  input wire logic [NUM_UIN-1:0] uin_out2_logic,
  input wire logic [NUM_UIN-1:0] universal_input_n,
  input wire logic [NUM_DIN-1:0] digital_input_n,
  input wire logic [NUM_DIN-1:0] din_cfg_we,
  input wire tivp_pkg::tivp_val_t din_value [NUM_DIN],
  input wire logic [NUM_DIN-1:0] din_logic,
  input wire tivp_pkg::tivp_val_t run_value,
  input wire logic run_logic,
  input wire tivp_pkg::tivp_val_t armature_current,
  input wire logic armature_current_out_rectify,
  input wire logic signed [12:0] analog_output_n [NUM_PAOUT+1]
);
  // --------
  // settling after reset
  // --------
  // outputs leave zero on the first edge, so history is skipped
  logic [1:0] age_reg;
  logic settled;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) age_reg <= 2'h0;
    else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
  end
  assign settled = (age_reg == 2'h3);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // --------
  // assertions
  // --------
  a_out1_zero_read: assert property (
    uin_out1_logic[0] == (uin_out1[0] != 16'sh0000))
    else $error("out1 logic reading wrong");
  a_out2_zero_read: assert property (
    uin_out2_logic[0] == (uin_out2[0] != 16'sh0000))
    else $error("out2 logic reading wrong");
  a_din_zero_read: assert property (
    din_logic[0] == (din_value[0] != 16'sh0000))
    else $error("din logic reading wrong");
  a_run_zero_read: assert property (
    run_logic == (run_value != 16'sh0000))
    else $error("run logic reading wrong");
  a_code_range_limit: assert property (
    analog_output_n[0] <= 13'sh0FFF && analog_output_n[0] >= -13'sh0FFF &&
    analog_output_n[1] <= 13'sh0FFF && analog_output_n[1] >= -13'sh0FFF &&
    analog_output_n[2] <= 13'sh0FFF && analog_output_n[2] >= -13'sh0FFF)
    else $error("analog code beyond 12 bits plus sign");
  a_arm_bipolar_follow: assert property (settled &&
    !$past(armature_current_out_rectify) &&
    $past(armature_current) <= 16'sh2710 &&
    $past(armature_current) >= -16'sh2710 |->
    analog_output_n[3] == $past(armature_current) * 16'sh0002 / 16'sh0005)
    else $error("armature code does not follow current");
  a_arm_rectified_sign: assert property (settled &&
    $past(armature_current_out_rectify) |-> analog_output_n[3] >= 13'sh0000)
    else $error("rectified armature code is negative");
  a_sel_hold_stable: assert property (settled &&
    $stable(universal_input_n[0]) && !$past(uin_cfg_we[0], 2) |->
    $stable(uin_out1[0]) && $stable(uin_out2[0]))
    else $error("selected value moved without cause");
  a_din_hold_stable: assert property (settled &&
    $past(digital_input_n[0]) == $past(digital_input_n[0], 2) &&
    !$past(din_cfg_we[0], 2) |-> $stable(din_value[0]))
    else $error("digital value moved without cause");
  c_uin_high: cover property (universal_input_n[0] && uin_out1_logic[0]);
  c_code_sat: cover property (analog_output_n[0] == 13'sh0FFF);
  c_arm_rect: cover property (armature_current_out_rectify &&
    analog_output_n[3] != 13'sh0000);
endmodule

bind tivp_top tivp_monitor #(.NUM_UIN(NUM_UIN), .NUM_DIN(NUM_DIN),
  .NUM_PAOUT(NUM_PAOUT)) tivp_monitor_i (.clk, .reset_n, .uin_cfg_we,
  .uin_out1, .uin_out2, .uin_out1_logic, .uin_out2_logic,
  .universal_input_n, .digital_input_n, .din_cfg_we, .din_value, .din_logic,
  .run_value, .run_logic, .armature_current, .armature_current_out_rectify,
  .analog_output_n);
`default_nettype wire

// ==== testbench/tivp_top_tb.sv ====
/*
  Bench for tivp_top: directed corners, then seeded random traffic.
  Assumes the design and checker are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none
module tivp_top_tb;
  logic clk, reset_n, run_terminal, run_cfg_we, run_logic;
  logic scope_follow_display, arm_rectify_we, armature_current_out_rectify;
  logic [7:0] uin_cfg_we, uin_out1_logic, uin_out2_logic, universal_input_n;
  logic [3:0] digital_input_n, din_cfg_we, din_logic;
  logic [2:0] aout_cfg_we;
  tivp_pkg::tivp_val_t cfg_data, run_value, display_value, armature_current;
  tivp_pkg::tivp_val_t uin_raw_mv [8], aout_src_values [8], sv;
  tivp_pkg::tivp_val_t uin_out1 [8], uin_out2 [8], din_value [4];
  tivp_pkg::tivp_uin_field_t uin_cfg_field;
  tivp_pkg::tivp_din_field_t din_cfg_field, run_cfg_field, fl;
  tivp_pkg::tivp_aout_field_t aout_cfg_field;
  logic signed [12:0] analog_output_n [4];
  logic [31:0] seed, r, q;
  int bad_count, samples_checked;
  int st [8][5];
  int ds [5][2];
  int ao [3][4];
  int e1 [8], e2 [8], ed [5], ea [4];
  logic [7:0] ej;
  logic armr, ermr, vld, lvl, dwe;

  tivp_top tivp_top_i (.clk, .reset_n, .cfg_data, .uin_raw_mv, .uin_cfg_we,
    .uin_cfg_field, .uin_out1, .uin_out2, .uin_out1_logic, .uin_out2_logic,
    .universal_input_n, .digital_input_n, .din_cfg_we, .din_cfg_field,
    .din_value, .din_logic, .run_terminal, .run_cfg_we, .run_cfg_field,
    .run_value, .run_logic, .aout_src_values, .aout_cfg_we, .aout_cfg_field,
    .display_value, .scope_follow_display, .armature_current,
    .arm_rectify_we, .armature_current_out_rectify, .analog_output_n);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic longint lim(longint v, longint l);
    return (v > l) ? l : ((v < -l) ? -l : v);
  endfunction

  // zero divider saturates by the sign of the source
  function automatic int acode(int s, int d, int o, logic rc);
    longint v;
    v = (d == 0) ? ((s < 0) ? -65536 : 65536) : longint'(s) * 10000 / d;
    v = lim(v + o, 11300);
    if (rc && v < 0) v = -v;
    return int'(lim(v * 2 / 5, 4095));
  endfunction

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // kind 0 universal input, 1 analog output, 2 armature rectify
  task automatic wr(input int kind, input int i, input int f, input int d);
    @(posedge clk);
    cfg_data <= 16'(d);
    uin_cfg_field <= tivp_pkg::tivp_uin_field_t'(f);
    aout_cfg_field <= tivp_pkg::tivp_aout_field_t'(f);
    if (kind == 0) uin_cfg_we[i] <= 1'b1;
    if (kind == 1) aout_cfg_we[i] <= 1'b1;
    if (kind == 2) arm_rectify_we <= 1'b1;
    @(posedge clk);
    uin_cfg_we <= 8'h00;
    aout_cfg_we <= 3'h0;
    arm_rectify_we <= 1'b0;
  endtask

  // --------
  // reference model, reads inputs before the edge's updates land
  // --------
  always @(posedge clk) begin
    vld = reset_n;
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) st[i] = '{6000, 1, 0, 1, 0};
      for (int i = 0; i < 5; i++) ds[i] = '{1, 0};
      for (int k = 0; k < 3; k++) ao[k] = '{k, 10000, 0, 0};
      armr = 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        ej[i] = uin_raw_mv[i] > st[i][0];
        e1[i] = st[i][ej[i] ? 1 : 2];
        e2[i] = st[i][ej[i] ? 3 : 4];
        if (uin_cfg_we[i]) st[i][uin_cfg_field] = int'(lim(cfg_data, 30000));
      end
      for (int i = 0; i < 5; i++) begin
        lvl = (i < 4) ? digital_input_n[i] : run_terminal;
        dwe = (i < 4) ? din_cfg_we[i] : run_cfg_we;
        fl = (i < 4) ? din_cfg_field : run_cfg_field;
        ed[i] = ds[i][lvl ? 0 : 1];
        if (dwe) ds[i][fl] = int'(lim(cfg_data, 30000));
      end
      for (int k = 0; k < 3; k++) begin
        sv = (k == 2 && scope_follow_display) ? display_value
          : aout_src_values[ao[k][0]];
        ea[k] = acode(sv, ao[k][1], ao[k][2], ao[k][3][0]);
        if (aout_cfg_we[k]) begin
          ao[k][aout_cfg_field] = int'(lim(cfg_data, 30000));
          if (aout_cfg_field == tivp_pkg::TIVP_AOUT_SOURCE) ao[k][0] = cfg_data[2:0];
          if (aout_cfg_field == tivp_pkg::TIVP_AOUT_RECTIFY) ao[k][3] = cfg_data[0];
        end
      end
      ea[3] = acode(armature_current, 10000, 0, armr);
      if (arm_rectify_we) armr = cfg_data[0];
      ermr = armr;
    end
  end

  always @(negedge clk) begin
    if (vld && reset_n) begin
      chk(universal_input_n === ej, "judgement");
      for (int i = 0; i < 8; i++) begin
        chk(uin_out1[i] === e1[i] && uin_out2[i] === e2[i], "uin value");
        chk(uin_out1_logic[i] === (e1[i] != 0), "out1 logic");
        chk(uin_out2_logic[i] === (e2[i] != 0), "out2 logic");
      end
      for (int i = 0; i < 4; i++) chk(din_value[i] === ed[i] &&
        din_logic[i] === (ed[i] != 0), "din");
      chk(run_value === ed[4] && run_logic === (ed[4] != 0), "run");
      for (int k = 0; k < 4; k++) chk(analog_output_n[k] === ea[k], "code");
      chk(armature_current_out_rectify === ermr, "rectify flag");
    end
  end

  initial begin
    seed = 32'h0000_0036;
    bad_count = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    cfg_data = 16'sh0000;
    uin_raw_mv = '{6000, 6001, -999, -999, 0, 0, 0, 0};
    aout_src_values = '{10000, -5000, 2500, 0, 0, 0, 0, 0};
    uin_cfg_we = 8'h00;
    uin_cfg_field = tivp_pkg::TIVP_UIN_THRESHOLD;
    digital_input_n = 4'h5;
    din_cfg_we = 4'h0;
    din_cfg_field = tivp_pkg::TIVP_DIN_HIGH;
    run_terminal = 1'b0;
    run_cfg_we = 1'b0;
    run_cfg_field = tivp_pkg::TIVP_DIN_HIGH;
    aout_cfg_we = 3'h0;
    aout_cfg_field = tivp_pkg::TIVP_AOUT_SOURCE;
    display_value = 16'sh09C4;
    scope_follow_display = 1'b0;
    armature_current = 16'sh0000;
    arm_rectify_we = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk(universal_input_n[3:0] === 4'h2, "default threshold");
    chk(uin_out1[1] === 16'sh0001 && uin_out2[0] === 16'sh0000, "levels");
    chk(analog_output_n[0] === 13'sh0FA0, "full scale");
    chk(analog_output_n[1] === -13'sh07D0, "second source");
    chk(analog_output_n[2] === 13'sh03E8, "third source");
    chk(din_value[0] === 16'sh0001 && din_value[1] === 16'sh0000, "din");
    chk(armature_current_out_rectify === 1'b0, "rectify reset");
    wr(0, 3, 0, -1000);
    wr(0, 3, 3, -150);
    wr(0, 2, 1, 0);
    wr(0, 2, 2, 1);
    repeat (2) @(negedge clk);
    chk(universal_input_n[3] === 1'b1, "negative threshold");
    chk(uin_out2[3] === -16'sh0096 && uin_out1[3] === 16'sh0001, "two");
    chk(uin_out1_logic[2] === 1'b1, "inverted sense");
    @(posedge clk);
    aout_src_values[0] <= 16'sh0000;
    wr(1, 0, 2, 1000);
    repeat (2) @(negedge clk);
    chk(analog_output_n[0] === 13'sh0190, "offset");
    wr(1, 0, 1, 5000);
    repeat (2) @(negedge clk);
    chk(analog_output_n[0] === 13'sh0190, "offset after divider");
    wr(1, 1, 3, 1);
    wr(1, 2, 0, 3);
    @(posedge clk);
    scope_follow_display <= 1'b1;
    armature_current <= -16'sh1388;
    wr(2, 0, 0, 1);
    repeat (2) @(negedge clk);
    chk(analog_output_n[1] === 13'sh07D0, "rectified");
    chk(analog_output_n[2] === 13'sh03E8, "scope display");
    chk(analog_output_n[3] === 13'sh07D0, "armature rectified");
    repeat (3000) begin
      @(posedge clk);
      r = rnd();
      for (int i = 0; i < 8; i++) begin
        q = rnd();
        uin_raw_mv[i] <= (q[1:0] == 2'h0) ?
          16'(st[i][0] + int'(q[3:2]) - 1) : q[31:16];
        aout_src_values[i] <= 16'(rnd());
      end
      uin_cfg_we <= (r[3:0] == 4'h0) ? 8'(rnd()) : 8'h00;
      uin_cfg_field <= tivp_pkg::tivp_uin_field_t'(rnd() % 5);
      din_cfg_we <= (r[6:4] == 3'h0) ? 4'(rnd()) : 4'h0;
      din_cfg_field <= tivp_pkg::tivp_din_field_t'(r[7]);
      run_cfg_we <= (r[10:8] == 3'h0);
      run_cfg_field <= tivp_pkg::tivp_din_field_t'(r[11]);
      aout_cfg_we <= (r[14:12] == 3'h0) ? 3'(rnd()) : 3'h0;
      aout_cfg_field <= tivp_pkg::tivp_aout_field_t'(r[16:15]);
      arm_rectify_we <= (r[19:17] == 3'h0);
      cfg_data <= (r[16:15] == 2'h2) ?
        16'(int'(rnd() % 60001) - 30000) : 16'(rnd());
      digital_input_n <= r[23:20];
      run_terminal <= r[24];
      scope_follow_display <= r[25];
      display_value <= 16'(rnd());
      armature_current <= 16'(rnd());
    end
    repeat (2) @(negedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
